// File: bench/cmp_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none
// port relations of the comparator control, lane 0 watched
module cmp_ctrl_checker
#(
	parameter int N = 2 // comparator count
)
(
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic [N-1:0] raw_cmp, // raw verdict
	input wire logic [N-1:0] cfg_on, // enable
	input wire logic [N-1:0] cfg_inv, // invert
	input wire logic [N-1:0] cfg_hys, // hysteresis
	input wire logic [N-1:0] cfg_rise, // rise enable
	input wire logic [3*N-1:0] cfg_pch, // positive select
	input wire logic [N-1:0] flag_clr, // flag clear
	input wire logic [N-1:0] compare_result_bit, // result
	input wire logic [N-1:0] mirrored_result_bit, // mirror
	input wire logic [N-1:0] ext_result, // external
	input wire logic [N-1:0] tmr_gate_src, // gate source
	input wire logic [N-1:0] compare_irq_flag, // flag
	input wire logic [N-1:0] ana_enable, // bias
	input wire logic [N-1:0] ana_hys, // hysteresis out
	input wire logic [N*cmp_pkg::CH_W-1:0] pos_connect, // positive switches
	input wire logic [N*cmp_pkg::CH_W-1:0] neg_connect // negative switches
);
	// --------
	// assertions
	// --------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	mirror_eq_a: assert property (compare_result_bit == mirrored_result_bit)
		else $error("mirror differs from result");
	gate_eq_a: assert property (ext_result == tmr_gate_src)
		else $error("gate source differs from pin result");
	raw_lat_a: assert property (($rose(raw_cmp[0]) && cfg_on[0] && !cfg_inv[0])
		##1 (raw_cmp[0] && cfg_on[0] && !cfg_inv[0])[*2] |=> compare_result_bit[0])
		else $error("result late after raw rise");
	inv_off_a: assert property ((!cfg_on[0] && $past(!cfg_on[0]))
		|=> compare_result_bit[0] == $past(cfg_inv[0]))
		else $error("idle result not polarity");
	rise_flag_a: assert property (($rose(compare_result_bit[0]) && cfg_rise[0])
		|=> compare_irq_flag[0])
		else $error("rise did not set flag");
	flag_hold_a: assert property ((compare_irq_flag[0] && !flag_clr[0]) |=> compare_irq_flag[0])
		else $error("flag dropped by itself");
	flag_clr_a: assert property ((flag_clr[0] && $stable(compare_result_bit[0]))
		|=> !compare_irq_flag[0])
		else $error("flag not cleared");
	copy_out_a: assert property ({ana_enable, ana_hys} == $past({cfg_on, cfg_hys}))
		else $error("analog enables wrong");
	off_disc_a: assert property ((!cfg_on[0])[*2]
		|=> (pos_connect[6:0] == 7'h00 && neg_connect[6:0] == 7'h00))
		else $error("switch closed while off");
	dac_sel_a: assert property ((cfg_on[0] && cfg_pch[2:0] == cmp_pkg::PCH_DAC)[*2]
		|=> pos_connect[6:0] == 7'h10)
		else $error("converter switch wrong");
endmodule
bind cmp_ctrl cmp_ctrl_checker #(.N(N)) chk (.clk, .rst_n, .raw_cmp, .cfg_on, .cfg_inv,
	.cfg_hys, .cfg_rise, .cfg_pch, .flag_clr, .compare_result_bit, .mirrored_result_bit,
	.ext_result, .tmr_gate_src, .compare_irq_flag, .ana_enable, .ana_hys, .pos_connect,
	.neg_connect);
`default_nettype wire

// File: bench/cmp_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
// self-checking bench of the comparator control
module cmp_ctrl_tb;
	typedef struct packed {logic [1:0] lvl; logic [1:0] inv; logic [1:0] res;} cmp_row_t;
	cmp_row_t rows[5] = '{'{2'h0, 2'h0, 2'h0}, '{2'h3, 2'h0, 2'h3}, '{2'h0, 2'h3, 2'h3},
		'{2'h3, 2'h3, 2'h0}, '{2'h1, 2'h2, 2'h3}};
	logic [2:0] code[5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7}; // selects
	logic [6:0] hot[5] = '{7'h01, 7'h02, 7'h10, 7'h20, 7'h40}; // switch
	logic clk = 1'b0, rst_n = 1'b0, run = 1'b0;
	logic [1:0] lvl = 2'h0, on = 2'h0, inv = 2'h0, hys = 2'h0, syn = 2'h0;
	logic [1:0] rise = 2'h0, fall = 2'h0, clr = 2'h0, raw, tck;
	logic [1:0] res, mir, ext, gate, flag, aen, ahys;
	logic [5:0] pch = 6'h00, nch = 6'h00;
	logic [13:0] pcon, ncon;
	int err_count = 0;
	int n_tests = 0;
	always #5 clk = ~clk;
	cmp_far far (.clk(clk), .rst_n(rst_n), .run(run), .lvl(lvl), .raw_cmp(raw), .tmr_clk(tck));
	cmp_ctrl #(.N(2)) dut (.clk(clk), .rst_n(rst_n), .raw_cmp(raw), .tmr_clk(tck), .cfg_on(on),
		.cfg_inv(inv), .cfg_hys(hys), .cfg_sync(syn), .cfg_rise(rise), .cfg_fall(fall),
		.cfg_pch(pch), .cfg_nch(nch), .flag_clr(clr), .compare_result_bit(res),
		.mirrored_result_bit(mir), .ext_result(ext), .tmr_gate_src(gate),
		.compare_irq_flag(flag), .ana_enable(aen), .ana_hys(ahys), .pos_connect(pcon),
		.neg_connect(ncon));
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// --------
	// watchdog, far beyond the run
	// --------
	initial
	begin
		#20000;
		err_count++;
		wrap_up();
	end
	initial
	begin
		tick(4);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK("reset", {res, ext, flag, aen, pcon}, 22'h0)
		tick(1);
		on <= 2'h3;
		hys <= 2'h1;
		foreach (rows[i])
		begin
			tick(1);
			lvl <= rows[i].lvl;
			inv <= rows[i].inv;
			tick(6);
			@(negedge clk);
			`CHK("result", rows[i].res, res)
			`CHK("external", rows[i].res, ext)
			`CHK("mirror", rows[i].res, mir)
			`CHK("gate", rows[i].res, gate)
		end
		foreach (code[i])
		begin
			tick(1);
			pch <= {2{code[i]}};
			tick(3);
			@(negedge clk);
			`CHK("pos switch", {2{hot[i]}}, pcon)
			`CHK("neg switch", 14'h0081, ncon)
		end
		`CHK("hys out", 2'h1, ahys)
		`CHK("enable", 2'h3, aen)
		// falls with fall disabled must leave the flag clear
		tick(1);
		inv <= 2'h0;
		lvl <= 2'h0;
		rise <= 2'h3;
		tick(6);
		@(negedge clk);
		`CHK("no flag", 2'h0, flag)
		// clear lands with an enabled edge: set wins
		tick(1);
		lvl <= 2'h3;
		// clear is sampled at the very edge that sees the rise
		tick(3);
		clr <= 2'h3;
		tick(1);
		clr <= 2'h0;
		tick(2);
		@(negedge clk);
		`CHK("set wins", 2'h3, flag)
		tick(1);
		clr <= 2'h3;
		tick(1);
		clr <= 2'h0;
		@(negedge clk);
		`CHK("cleared", 2'h0, flag)
		// switching off drops the result: a falling edge
		tick(1);
		on <= 2'h0;
		rise <= 2'h0;
		fall <= 2'h3;
		tick(4);
		@(negedge clk);
		`CHK("off edge", 2'h3, flag)
		`CHK("off result", 2'h0, res)
		`CHK("off switch", 14'h0, pcon)
		tick(1);
		clr <= 2'h3;
		inv <= 2'h3;
		tick(1);
		clr <= 2'h0;
		tick(3);
		inv <= 2'h0;
		tick(3);
		@(negedge clk);
		`CHK("polarity edge", 2'h3, flag)
		// timer runs to latch a high result, then stops: synced output must hold
		tick(1);
		on <= 2'h3;
		syn <= 2'h3;
		run <= 1'b1;
		tick(16);
		run <= 1'b0;
		tick(8);
		lvl <= 2'h0;
		tick(8);
		@(negedge clk);
		`CHK("sync res", 2'h0, res)
		`CHK("sync hold", 2'h3, ext)
		tick(1);
		run <= 1'b1;
		tick(20);
		@(negedge clk);
		`CHK("sync update", 2'h0, gate)
		wrap_up();
	end
endmodule
`default_nettype wire

// File: bench/cmp_far.sv
`timescale 1ns/1ns
`default_nettype none
// analog inputs and prescaled timer clock
module cmp_far
(
	input wire logic clk, // instruction clock
	input wire logic rst_n, // reset
	input wire logic run, // timer running
	input wire logic [1:0] lvl, // p above n
	output logic [1:0] raw_cmp, // raw verdict
	output logic [1:0] tmr_clk // prescaled clock
);
	logic [1:0] div_ff; // divide by four
	logic [1:0] nxt_div; // next divider
	// clock stands low while stopped, so no stray fall
	always_comb
	begin
		nxt_div = run ? div_ff + 2'h1 : 2'h0;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div_ff <= 2'h0;
		else
			div_ff <= nxt_div;
	end
	assign tmr_clk = {2{div_ff[1]}};
	assign raw_cmp = lvl;
endmodule
`default_nettype wire

// File: verilog/cmp_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// digital control of a dual comparator unit
module cmp_ctrl
#(
	parameter int N = cmp_pkg::NUM_CMP // comparator count
)
(
	input wire logic clk, // instruction clock, 100 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic [N-1:0] raw_cmp, // analog raw p>n per comparator
	input wire logic [N-1:0] tmr_clk, // prescaled timer source clock
	input wire logic [N-1:0] cfg_on, // comparator_on_bit
	input wire logic [N-1:0] cfg_inv, // invert_output_bit
	input wire logic [N-1:0] cfg_hys, // hysteresis_bit
	input wire logic [N-1:0] cfg_sync, // timer_sync_bit
	input wire logic [N-1:0] cfg_rise, // rise_irq_enable
	input wire logic [N-1:0] cfg_fall, // fall_irq_enable
	input wire logic [3*N-1:0] cfg_pch, // positive_channel_select per comparator
	input wire logic [3*N-1:0] cfg_nch, // negative channel select per comparator
	input wire logic [N-1:0] flag_clr, // clearing write to irq flags
	output logic [N-1:0] compare_result_bit, // result in first control register
	output logic [N-1:0] mirrored_result_bit, // result_mirror_register bits
	output logic [N-1:0] ext_result, // result to pin_output_select and gate
	output logic [N-1:0] tmr_gate_src, // gate source offered to timer
	output logic [N-1:0] compare_irq_flag, // irq_flag_register_2 bits
	output logic [N-1:0] ana_enable, // analog bias enable
	output logic [N-1:0] ana_hys, // analog hysteresis enable
	output logic [N*cmp_pkg::CH_W-1:0] pos_connect, // positive channel switches
	output logic [N*cmp_pkg::CH_W-1:0] neg_connect // negative channel switches
);
	// ------------------------------------------------
	// channel decode
	// ------------------------------------------------
	// positive: pins 0,1, dac, fvr, gnd; others unconnected
	function automatic logic [cmp_pkg::CH_W-1:0] pos_dec(input logic on, input logic [2:0] s);
		logic [cmp_pkg::CH_W-1:0] v;
		v = '0;
		case (s)
			cmp_pkg::PCH_IN0: v[0] = 1'b1;
			cmp_pkg::PCH_IN1: v[1] = 1'b1;
			cmp_pkg::PCH_DAC: v[4] = 1'b1;
			cmp_pkg::PCH_FVR: v[5] = 1'b1;
			cmp_pkg::PCH_GND: v[6] = 1'b1;
			default: v = '0;
		endcase
		return on ? v : '0; // off disconnects all
	endfunction

	// negative: pins 0..3, fvr, gnd; 4 and 5 unconnected
	function automatic logic [cmp_pkg::CH_W-1:0] neg_dec(input logic on, input logic [2:0] s);
		logic [cmp_pkg::CH_W-1:0] v;
		v = '0;
		case (s)
			3'h0, 3'h1, 3'h2, 3'h3: v[s[1:0]] = 1'b1;
			3'h6: v[5] = 1'b1;
			cmp_pkg::NCH_GND: v[6] = 1'b1;
			default: v = '0;
		endcase
		return on ? v : '0;
	endfunction

	// ------------------------------------------------
	// input synchronisers
	// ------------------------------------------------
	logic [N-1:0] raw_s; // raw compare after two flops
	logic [N-1:0] tck_s; // timer clock after two flops

	// raw comparator output is analog-timed, so it is synchronised
	cmp_sync #(.W(N)) u_raw_sync
	(
		.clk(clk),
		.rst_n(rst_n),
		.d(raw_cmp),
		.q(raw_s)
	);

	// the prescaled timer clock arrives from the timer
	cmp_sync #(.W(N)) u_tck_sync
	(
		.clk(clk),
		.rst_n(rst_n),
		.d(tmr_clk),
		.q(tck_s)
	);

	// ------------------------------------------------
	// result path state
	// ------------------------------------------------
	logic [N-1:0] res_ff; // latched internal result
	logic [N-1:0] syn_ff; // timer-synchronised result
	logic [N-1:0] ext_ff; // pin/gate output
	logic [N-1:0] on_ff; // registered enable to analog
	logic [N-1:0] hys_ff; // registered hysteresis to analog
	cmp_pkg::cmp_tck_t tck_ff [N]; // timer clock level tracker
	logic [N*cmp_pkg::CH_W-1:0] pcon_ff; // positive switches
	logic [N*cmp_pkg::CH_W-1:0] ncon_ff; // negative switches
	logic [N-1:0] nxt_res;
	logic [N-1:0] nxt_syn;
	logic [N-1:0] nxt_ext;
	logic [N-1:0] nxt_on;
	logic [N-1:0] nxt_hys;
	cmp_pkg::cmp_tck_t nxt_tck [N];
	logic [N*cmp_pkg::CH_W-1:0] nxt_pcon;
	logic [N*cmp_pkg::CH_W-1:0] nxt_ncon;
	logic [N-1:0] cur; // polarity-corrected result

	// next values for the result path
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			// disabled comparator reads low raw; polarity still applies,
			// so toggling on/inv can make an edge
			cur[i] = (cfg_on[i] & raw_s[i]) ^ cfg_inv[i];
			nxt_res[i] = cur[i]; // latched each cycle
			nxt_syn[i] = syn_ff[i];
			nxt_tck[i] = tck_s[i] ? cmp_pkg::CMP_TCK_HIGH : cmp_pkg::CMP_TCK_LOW;
			case (tck_ff[i])
				cmp_pkg::CMP_TCK_HIGH:
				begin
					// falling edge of timer clock: capture
					if (!tck_s[i])
						nxt_syn[i] = cur[i];
				end
				cmp_pkg::CMP_TCK_LOW:
				begin
					nxt_syn[i] = syn_ff[i]; // hold while low or rising
				end
				default:
				begin
					nxt_syn[i] = syn_ff[i];
				end
			endcase
			// external path unlatched unless sync chosen
			nxt_ext[i] = cfg_sync[i] ? nxt_syn[i] : cur[i];
			nxt_on[i] = cfg_on[i];
			nxt_hys[i] = cfg_hys[i];
			nxt_pcon[i*cmp_pkg::CH_W +: cmp_pkg::CH_W] = pos_dec(cfg_on[i], cfg_pch[3*i +: 3]);
			nxt_ncon[i*cmp_pkg::CH_W +: cmp_pkg::CH_W] = neg_dec(cfg_on[i], cfg_nch[3*i +: 3]);
		end
	end

	// registers of the result path; all zero after reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			res_ff <= '0;
			syn_ff <= '0;
			ext_ff <= '0;
			on_ff <= '0;
			hys_ff <= '0;
			pcon_ff <= '0;
			ncon_ff <= '0;
			for (int i = 0; i < N; i++)
				tck_ff[i] <= cmp_pkg::CMP_TCK_LOW;
		end
		else
		begin
			res_ff <= nxt_res;
			syn_ff <= nxt_syn;
			ext_ff <= nxt_ext;
			on_ff <= nxt_on;
			hys_ff <= nxt_hys;
			pcon_ff <= nxt_pcon;
			ncon_ff <= nxt_ncon;
			for (int i = 0; i < N; i++)
				tck_ff[i] <= nxt_tck[i];
		end
	end

	// ------------------------------------------------
	// edge detectors and flags
	// ------------------------------------------------
	logic [N-1:0] flag_w; // flags from detectors

	// one detector pair per comparator
	for (genvar g = 0; g < N; g++)
	begin : g_edge
		cmp_edge u_edge
		(
			.clk(clk),
			.rst_n(rst_n),
			.res(res_ff[g]),
			.rise_en(cfg_rise[g]),
			.fall_en(cfg_fall[g]),
			.flag_clr(flag_clr[g]),
			.flag(flag_w[g])
		);
	end

	// ------------------------------------------------
	// outputs, all from flops
	// ------------------------------------------------
	assign compare_result_bit = res_ff;
	assign mirrored_result_bit = res_ff;
	assign ext_result = ext_ff; // to pin select
	assign tmr_gate_src = ext_ff; // gate source
	assign compare_irq_flag = flag_w;
	assign ana_enable = on_ff;
	assign ana_hys = hys_ff;
	assign pos_connect = pcon_ff;
	assign neg_connect = ncon_ff;
endmodule
`default_nettype wire

// File: verilog/cmp_edge.sv
`timescale 1ns/1ns
`default_nettype none
// rise/fall detector with sticky flag, set beats clear
module cmp_edge
(
	input wire logic clk, // instruction clock
	input wire logic rst_n, // async reset, active low
	input wire logic res, // latched result of this comparator
	input wire logic rise_en, // rise_irq_enable
	input wire logic fall_en, // fall_irq_enable
	input wire logic flag_clr, // software clear pulse
	output logic flag // compare_irq_flag
);
	// ------------------------------------------------
	// state
	// ------------------------------------------------
	logic prev_ff; // result one cycle ago
	logic flag_ff; // sticky flag
	logic nxt_prev;
	logic nxt_flag;
	logic rise; // rising edge seen
	logic fall; // falling edge seen

	// next-state: edges always watched, even when off
	always_comb
	begin
		rise = res & ~prev_ff;
		fall = ~res & prev_ff;
		nxt_prev = res;
		nxt_flag = flag_ff;
		if (flag_clr)
			nxt_flag = 1'b0; // only software clears
		if ((rise & rise_en) | (fall & fall_en))
			nxt_flag = 1'b1; // set wins over clear
	end

	// registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_ff <= 1'b0;
			flag_ff <= 1'b0;
		end
		else
		begin
			prev_ff <= nxt_prev;
			flag_ff <= nxt_flag;
		end
	end

	assign flag = flag_ff;
endmodule
`default_nettype wire

// File: verilog/cmp_pkg.sv
package cmp_pkg;
	// ------------------------------------------------
	// counts and codes
	// ------------------------------------------------
	localparam int NUM_CMP = 2; // comparators in the unit
	localparam logic [2:0] PCH_IN0 = 3'h0; // positive input pin 0
	localparam logic [2:0] PCH_IN1 = 3'h1; // positive input pin 1
	localparam logic [2:0] PCH_DAC = 3'h5; // converter output
	localparam logic [2:0] PCH_FVR = 3'h6; // reference buffer
	localparam logic [2:0] PCH_GND = 3'h7; // analog ground
	localparam logic [2:0] NCH_GND = 3'h7; // negative ground code
	localparam logic [2:0] CH_RST = 3'h0; // channel select after reset
	localparam logic CTRL_RST = 1'b0; // every control bit after reset
	// channel connect one-hot width: pins 0..3, dac, fvr, gnd
	localparam int CH_W = 7;
	// timer clock edge detector states
	typedef enum logic [1:0] {
		CMP_TCK_LOW = 2'b00,
		CMP_TCK_HIGH = 2'b01
	} cmp_tck_t;
endpackage

// File: verilog/cmp_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for pin-side inputs
module cmp_sync
#(
	parameter int W = 1 // bits to synchronise
)
(
	input wire logic clk, // instruction clock
	input wire logic rst_n, // async reset, active low
	input wire logic [W-1:0] d, // asynchronous input
	output logic [W-1:0] q // synchronised output
);
	// ------------------------------------------------
	// stages
	// ------------------------------------------------
	logic [W-1:0] s1_ff; // first stage, read only by second
	logic [W-1:0] s2_ff; // second stage
	logic [W-1:0] nxt_s1;
	logic [W-1:0] nxt_s2;

	// next values
	always_comb
	begin
		nxt_s1 = d;
		nxt_s2 = s1_ff;
	end

	// registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
		end
		else
		begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
		end
	end

	assign q = s2_ff;
endmodule
`default_nettype wire
